/* File: rtl/acs_regs.vh */
// Function
// [R1] converter clock derived by internal prescaler
// [R2] halt in debug unless debug run set
// [R3] start bit starts, reads one while busy
// [R4] single mode clears start bit on completion
// [R5] channel change waits for conversion end
// [R6] result single or accumulated per count setting
// [R7] completion sets result ready flag
// [R8] irq needs enable and global enable
// [R9] flag sets even with interrupt disabled
// [R10] event input enable lets events trigger
// [R11] event edge sets start bit
// [R12] free run first conversion by software
// [R13] free run restarts and flags each result
// [R14] result codes unsigned, zero lowest
// [R15] software configures first, enables last
// [R16] reference resets to internal reference
// [R17] start on next converter clock edge
// [R18] thirteen cycles, sample at two
// [R19] flag clears on result read or write one
// [R20] prescaler zero while disabled
// [R21] start while busy does not restart
// [R22] disabled block ignores all triggers
`ifndef ACS_REGS_VH
`define ACS_REGS_VH
// =====================================================
// register offsets
`define ACS_CONTROL_A 12'h000
`define ACS_CTRLB 12'h004
`define ACS_CTRLC 12'h008
`define ACS_MUX 12'h00c
`define ACS_CMD 12'h010
`define ACS_EVENT_CTRL 12'h014
`define ACS_INT_CTRL 12'h018
`define ACS_INT_FLAG 12'h01c
`define ACS_RES 12'h020
`define ACS_DBGCTRL 12'h024
// =====================================================
// field positions
`define ACS_EN_BIT 0
`define ACS_FREE_RUN_BIT 1
`define ACS_RESOLUTION_BIT 2
`define ACS_REF_SEL_LSB 4
`define ACS_PRESCALE_LSB 0
// =====================================================
// reset values and timing
`define ACS_REF_SEL_RST 2'h0
`define ACS_CONV_CYCLES 4'hd
`define ACS_SH_CYCLE 4'h2
`endif

/* File: rtl/acs_prescaler.v */
`timescale 1ns/1ps
// =====================================================
// converter clock prescaler: one-cycle enable pulses
module acs_prescaler (
  input wire pclk,
  input wire presetn,
  input wire run,
  input wire [2:0] prescale_sel,
  output reg tick_q
);
  reg [7:0] cnt_q;
  wire [7:0] lim;
  // factor 2^(sel+1); period in pclk cycles
  assign lim = (8'h02 << prescale_sel) - 8'h01;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    // [R20] held at zero when stopped
    end else if (!run) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else if (cnt_q == lim) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      tick_q <= 1'b0;
    end
  end
endmodule

/* File: rtl/acs_sequencer.v */
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "acs_regs.vh"
// =====================================================
// conversion sequencer with apb slave
module acs_sequencer (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire start_event,
  input wire debug_halt,
  input wire global_int_enable,
  input wire [9:0] sar_data,
  output reg irq_q,
  output reg sample_hold_q,
  output reg [3:0] active_channel_q,
  output reg [1:0] active_reference_q
);
  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  reg [7:0] control_a_q;
  reg [2:0] prescale_q;
  reg [1:0] ref_sel_q;
  reg [2:0] accum_count_q;
  reg [3:0] mux_q;
  reg start_conversion_bit_q;
  reg start_event_input_enable_q;
  reg result_ready_ie_q;
  reg result_ready_flag_q;
  reg debug_run_bit_q;
  reg [15:0] res_q;
  reg [15:0] acc_q;
  reg [6:0] samp_cnt_q;
  reg [3:0] cyc_q;
  reg state_q;
  reg ev_s1_q;
  reg ev_s2_q;
  reg ev_s3_q;
  reg dbg_s1_q;
  reg dbg_s2_q;
  wire tick;
  wire enable;
  wire free_running_enable;
  wire halted;
  wire wr;
  wire rd;
  wire ev_edge;
  wire conv_done;
  wire last_sample;
  wire [15:0] acc_sum;
  wire [9:0] sample;

  function sel_hit;
    input [11:0] a;
    input [11:0] off;
    begin
      sel_hit = (a == off);
    end
  endfunction

  assign enable = control_a_q[`ACS_EN_BIT];
  assign free_running_enable = control_a_q[`ACS_FREE_RUN_BIT];
  // [R2] debug halt freezes unless run bit set
  assign halted = dbg_s2_q & ~debug_run_bit_q;
  assign wr = psel & penable & pwrite & pready;
  assign rd = psel & penable & ~pwrite & pready;
  // [R11] rising edge of synchronised event
  assign ev_edge = ev_s2_q & ~ev_s3_q;
  // [R18] last cycle of thirteen
  assign conv_done = (state_q == ST_CONV) & tick & ~halted &
                     (cyc_q == `ACS_CONV_CYCLES - 4'h1);
  // [R6] burst of 2^count samples per result
  assign last_sample = (samp_cnt_q == ((7'h01 << accum_count_q) - 7'h01));
  // [R14] 8-bit mode drops low bits, unsigned code
  assign sample = control_a_q[`ACS_RESOLUTION_BIT] ? {2'b00, sar_data[9:2]}
                                                   : sar_data;
  assign acc_sum = acc_q + {6'h00, sample};

  // =====================================================
  // [R1] prescaler from pclk
  acs_prescaler i_acs_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    // [R17] prescaler runs only during conversion
    .run(enable & (state_q == ST_CONV)),
    .prescale_sel(prescale_q),
    .tick_q(tick)
  );

  // =====================================================
  // input synchronisers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_s1_q <= 1'b0;
      ev_s2_q <= 1'b0;
      ev_s3_q <= 1'b0;
      dbg_s1_q <= 1'b0;
      dbg_s2_q <= 1'b0;
    end else begin
      ev_s1_q <= start_event;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
      dbg_s1_q <= debug_halt;
      dbg_s2_q <= dbg_s1_q;
    end
  end

  // =====================================================
  // registers and sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_a_q <= 8'h00;
      prescale_q <= 3'h0;
      // [R16] internal reference after reset
      ref_sel_q <= `ACS_REF_SEL_RST;
      accum_count_q <= 3'h0;
      mux_q <= 4'h0;
      start_conversion_bit_q <= 1'b0;
      start_event_input_enable_q <= 1'b0;
      result_ready_ie_q <= 1'b0;
      result_ready_flag_q <= 1'b0;
      debug_run_bit_q <= 1'b0;
      res_q <= 16'h0000;
      acc_q <= 16'h0000;
      samp_cnt_q <= 7'h00;
      cyc_q <= 4'h0;
      state_q <= ST_IDLE;
      active_channel_q <= 4'h0;
      active_reference_q <= `ACS_REF_SEL_RST;
      sample_hold_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      sample_hold_q <= 1'b0;
      if (wr) begin
        if (sel_hit(paddr, `ACS_CONTROL_A))
          control_a_q <= pwdata[7:0];
        if (sel_hit(paddr, `ACS_CTRLB))
          accum_count_q <= (pwdata[2:0] > 3'h6) ? 3'h6 : pwdata[2:0];
        if (sel_hit(paddr, `ACS_CTRLC)) begin
          prescale_q <= pwdata[`ACS_PRESCALE_LSB +: 3];
          ref_sel_q <= pwdata[`ACS_REF_SEL_LSB +: 2];
        end
        if (sel_hit(paddr, `ACS_MUX))
          mux_q <= pwdata[3:0];
        if (sel_hit(paddr, `ACS_EVENT_CTRL))
          start_event_input_enable_q <= pwdata[0];
        if (sel_hit(paddr, `ACS_INT_CTRL))
          result_ready_ie_q <= pwdata[0];
        if (sel_hit(paddr, `ACS_DBGCTRL))
          debug_run_bit_q <= pwdata[0];
      end
      // [R19] clear by write one or result read
      if ((wr & sel_hit(paddr, `ACS_INT_FLAG) & pwdata[0]) |
          (rd & sel_hit(paddr, `ACS_RES)))
        result_ready_flag_q <= 1'b0;
      // [R22] disabled: no start, triggers ignored
      if (!enable) begin
        state_q <= ST_IDLE;
        start_conversion_bit_q <= 1'b0;
        cyc_q <= 4'h0;
        samp_cnt_q <= 7'h00;
        acc_q <= 16'h0000;
      end else begin
        // [R3] software start; [R12] also first free-run
        if (wr & sel_hit(paddr, `ACS_CMD) & pwdata[0])
          start_conversion_bit_q <= 1'b1;
        // [R10] events trigger when input enabled
        if (ev_edge & start_event_input_enable_q & ~halted)
          start_conversion_bit_q <= 1'b1;
        case (state_q)
          ST_IDLE: begin
            // [R5] selections follow while idle
            active_channel_q <= mux_q;
            active_reference_q <= ref_sel_q;
            if (start_conversion_bit_q & ~halted) begin
              state_q <= ST_CONV;
              cyc_q <= 4'h0;
            end
          end
          ST_CONV: begin
            // [R21] further starts ignored while busy
            if (tick & ~halted) begin
              cyc_q <= cyc_q + 4'h1;
              // [R18] sample-and-hold two cycles in
              if (cyc_q == `ACS_SH_CYCLE - 4'h1)
                sample_hold_q <= 1'b1;
            end
            if (conv_done) begin
              cyc_q <= 4'h0;
              // [R5] selections reload only at the end
              active_channel_q <= mux_q;
              active_reference_q <= ref_sel_q;
              if (last_sample) begin
                res_q <= acc_sum;
                acc_q <= 16'h0000;
                samp_cnt_q <= 7'h00;
                // [R7] [R9] flag regardless of enable
                result_ready_flag_q <= 1'b1;
                // [R13] free run continues at once
                if (!free_running_enable) begin
                  // [R4] single mode clears start bit
                  start_conversion_bit_q <= 1'b0;
                  state_q <= ST_IDLE;
                end
              end else begin
                acc_q <= acc_sum;
                samp_cnt_q <= samp_cnt_q + 7'h01;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
      // [R8] gated by both enables
      irq_q <= result_ready_flag_q & result_ready_ie_q & global_int_enable;
    end
  end

  // =====================================================
  // apb answer path, zero wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `ACS_CONTROL_A: prdata <= {24'h000000, control_a_q};
          `ACS_CTRLB: prdata <= {29'h00000000, accum_count_q};
          `ACS_CTRLC: prdata <= {26'h0000000, ref_sel_q, 1'b0, prescale_q};
          `ACS_MUX: prdata <= {28'h0000000, mux_q};
          `ACS_CMD: prdata <= {31'h00000000, start_conversion_bit_q};
          `ACS_EVENT_CTRL: prdata <= {31'h00000000,
                                      start_event_input_enable_q};
          `ACS_INT_CTRL: prdata <= {31'h00000000, result_ready_ie_q};
          `ACS_INT_FLAG: prdata <= {31'h00000000, result_ready_flag_q};
          `ACS_RES: prdata <= {16'h0000, res_q};
          `ACS_DBGCTRL: prdata <= {31'h00000000, debug_run_bit_q};
          default: pslverr <= psel & ~penable;
        endcase
      end else if (psel & ~penable & pwrite) begin
        case (paddr)
          `ACS_CONTROL_A, `ACS_CTRLB, `ACS_CTRLC, `ACS_MUX, `ACS_CMD,
          `ACS_EVENT_CTRL, `ACS_INT_CTRL, `ACS_INT_FLAG, `ACS_RES,
          `ACS_DBGCTRL: pslverr <= 1'b0;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule

/* File: tb/acs_chk.sv */
`timescale 1ns/1ps
// =====================================================
// port checks on the sequencer
module acs_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire global_int_enable,
  input wire irq_q,
  input wire sample_hold_q,
  input wire [3:0] active_channel_q,
  input wire [1:0] active_reference_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_phase: // bus answer
    assert property (pready |-> psel && penable) else $error("bad pready");
  chk_ready_pulse: // bus answer
    assert property (pready |=> !pready) else $error("long pready");
  chk_err_ready: // bus answer
    assert property (pslverr |-> pready) else $error("lone pslverr");
  chk_irq_gate: // global gate
    assert property (irq_q |-> $past(global_int_enable))
      else $error("irq without global enable");
  chk_irq_drop: // global gate
    assert property (!global_int_enable |=> !irq_q) else $error("irq stuck");
  // samples sit at least nine pclk cycles apart
  chk_sh_pulse: // sample spacing
    assert property (sample_hold_q |=> !sample_hold_q [*8])
      else $error("sample pulses too close");
  chk_chan_lock: // channel held
    assert property (sample_hold_q |-> $stable(active_channel_q))
      else $error("channel moved");
  chk_ref_lock: // reference held
    assert property (sample_hold_q |-> $stable(active_reference_q))
      else $error("reference moved");
endmodule
bind acs_sequencer acs_chk i_acs_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .global_int_enable(global_int_enable), .irq_q(irq_q),
  .sample_hold_q(sample_hold_q), .active_channel_q(active_channel_q),
  .active_reference_q(active_reference_q));

/* File: tb/acs_partner.sv */
`timescale 1ns/1ps
// =====================================================
// event source and analog core stand-in
module acs_partner #(
  parameter [9:0] CODE = 10'h3ff
) (
  input wire pclk,
  input wire fire,
  output logic start_event,
  output logic [9:0] sar_data
);
  logic [2:0] cnt_q = 3'h0;
  assign sar_data = CODE;
  // one clean rising edge
  // held several cycles so the two-flop sync cannot miss it
  always @(posedge pclk) begin
    if (fire)
      cnt_q <= 3'h4;
    else if (cnt_q != 3'h0)
      cnt_q <= cnt_q - 3'h1;
  end
  assign start_event = (cnt_q != 3'h0);
endmodule

/* File: tb/adc_conversion_sequencer_tb.sv */
`timescale 1ns/1ps
`include "acs_regs.vh"
// =====================================================
// bench
module adc_conversion_sequencer_tb;
  logic pclk, presetn, psel, penable, pwrite, debug_halt, gie, fire, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, q;
  wire [31:0] prdata;
  wire pready, pslverr, irq_q, sample_hold_q, start_event;
  wire [3:0] active_channel_q;
  wire [1:0] active_reference_q;
  wire [9:0] sar_data;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  acs_sequencer i_acs_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .start_event(start_event), .debug_halt(debug_halt),
    .global_int_enable(gie), .sar_data(sar_data), .irq_q(irq_q),
    .sample_hold_q(sample_hold_q), .active_channel_q(active_channel_q),
    .active_reference_q(active_reference_q));
  acs_partner i_acs_partner (.pclk(pclk), .fire(fire),
    .start_event(start_event), .sar_data(sar_data));
  always #50 pclk = ~pclk;
  // =====================================================
  // tasks
  task results;
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      results;
    end
  end
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    repeat (20) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wflag;
    repeat (80) begin
      apb(1'b0, `ACS_INT_FLAG, 32'h0);
      if (q[0] === 1'b1)
        break;
    end
  endtask
  // =====================================================
  // tests
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; debug_halt = 0; gie = 0; fire = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `ACS_CTRLC, 32'h0);
    chk("ctrlc", q, 32'h0);
    chk("ref out", 32'(active_reference_q), 32'h0);
    apb(1'b1, `ACS_MUX, 32'h3);
    apb(1'b1, `ACS_INT_CTRL, 32'h1);
    apb(1'b1, `ACS_EVENT_CTRL, 32'h1);
    gie <= 1'b1;
    apb(1'b1, `ACS_CMD, 32'h1);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (60) @(posedge pclk);
    apb(1'b0, `ACS_INT_FLAG, 32'h0);
    chk("idle flag", q, 32'h0);
    apb(1'b0, `ACS_CMD, 32'h0);
    chk("idle cmd", q, 32'h0);
    apb(1'b1, `ACS_EVENT_CTRL, 32'h0);
    apb(1'b1, `ACS_CONTROL_A, 32'h1);
    apb(1'b1, `ACS_CMD, 32'h1);
    apb(1'b0, `ACS_CMD, 32'h0);
    chk("busy", q, 32'h1);
    apb(1'b1, `ACS_MUX, 32'h5);
    repeat (100) begin
      @(negedge pclk);
      if (sample_hold_q === 1'b1)
        break;
    end
    chk("channel", 32'(active_channel_q), 32'h3);
    wflag;
    chk("flag", q, 32'h1);
    chk("irq", 32'(irq_q), 32'h1);
    apb(1'b0, `ACS_CMD, 32'h0);
    chk("cmd done", q, 32'h0);
    apb(1'b0, `ACS_RES, 32'h0);
    chk("result", q, 32'h3ff);
    apb(1'b0, `ACS_INT_FLAG, 32'h0);
    chk("read clear", q, 32'h0);
    gie <= 1'b0;
    apb(1'b1, `ACS_CTRLB, 32'h1);
    apb(1'b1, `ACS_EVENT_CTRL, 32'h1);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    wflag;
    chk("event flag", q, 32'h1);
    chk("no irq", 32'(irq_q), 32'h0);
    apb(1'b1, `ACS_INT_FLAG, 32'h1);
    apb(1'b0, `ACS_INT_FLAG, 32'h0);
    chk("w1c", q, 32'h0);
    apb(1'b0, `ACS_RES, 32'h0);
    chk("sum", q, 32'h7fe);
    apb(1'b1, `ACS_CTRLB, 32'h0);
    apb(1'b1, `ACS_EVENT_CTRL, 32'h0);
    debug_halt <= 1'b1;
    apb(1'b1, `ACS_CMD, 32'h1);
    repeat (60) @(posedge pclk);
    apb(1'b0, `ACS_INT_FLAG, 32'h0);
    chk("halt flag", q, 32'h0);
    debug_halt <= 1'b0;
    wflag;
    chk("resume flag", q, 32'h1);
    apb(1'b1, `ACS_INT_FLAG, 32'h1);
    apb(1'b1, `ACS_DBGCTRL, 32'h1);
    debug_halt <= 1'b1;
    apb(1'b1, `ACS_CMD, 32'h1);
    wflag;
    chk("debug run", q, 32'h1);
    apb(1'b1, `ACS_INT_FLAG, 32'h1);
    debug_halt <= 1'b0;
    apb(1'b1, `ACS_CONTROL_A, 32'h3);
    apb(1'b1, `ACS_CMD, 32'h1);
    wflag;
    apb(1'b1, `ACS_INT_FLAG, 32'h1);
    wflag;
    chk("rerun flag", q, 32'h1);
    apb(1'b0, `ACS_CMD, 32'h0);
    chk("rerun busy", q, 32'h1);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped", {q[30:0], e}, 32'h1);
    results;
  end
endmodule
